// *** prf_flags.v ***
// peripheral request flags, reset status, interrupt gating and pin routing
// assumes peripheral event strobes are one-cycle pulses on ref_clk and
// reset-cause strobes come from a reset controller on the same clock
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "prf_map.vh"

module prf_flags (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  // register port
  input wire [`PRF_ADDR_W-1:0] addr,
  input wire [`PRF_DATA_W-1:0] wr_data,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [`PRF_DATA_W-1:0] rd_data,
  // peripheral events
  input wire conversion_start,
  input wire conversion_done,
  input wire [1:0] ccp_mode,
  input wire capture_event,
  input wire compare_match,
  input wire comparator_out,
  input wire period_match,
  input wire timer_one_overflow,
  // reset causes
  input wire brownout_reset,
  input wire watchdog_reset,
  input wire external_reset_pin,
  output reg brownout_reset_enable,
  // interrupt
  output reg irq,
  // pwm routing
  input wire pwm_output_a,
  input wire pwm_output_b,
  output reg pwm_a_pin0,
  output reg pwm_a_pin0_oe,
  output reg pwm_a_pin1,
  output reg pwm_a_pin1_oe,
  output reg pwm_b_pin0,
  output reg pwm_b_pin0_oe,
  output reg pwm_b_pin1,
  output reg pwm_b_pin1_oe,
  // timer one gate routing
  input wire gate_pin0,
  input wire gate_pin1,
  output reg timer_one_gate
);

reg [7:0] peripheral_request_flags;
reg [7:0] enable_mask;
reg [7:0] interrupt_control;
reg [7:0] alternate_pin_select;
reg power_on_flag;
reg brownout_status_flag;
reg comparator_prev;
reg [2:0] comparator_settle;
reg [7:0] next_flags;
reg [7:0] flag_set;
reg [7:0] flag_clr;
reg [7:0] next_rd_data;
reg next_power_on_flag;
reg next_brownout_status_flag;
reg next_irq;
wire [2:0] async_pins;
wire [2:0] synced_pins;
wire comparator_sync;
wire gate0_sync;
wire gate1_sync;
wire comparator_change;
wire write_flags;
wire write_enable;
wire write_intctl;
wire write_rststat;
wire write_borctl;
wire write_apsel;
wire brownout_taken;
wire warm_reset;
wire global_interrupt_enable;
wire peripheral_interrupt_enable;
wire [7:0] pending;

assign async_pins = {gate_pin1, gate_pin0, comparator_out};
prf_sync #(
  .WIDTH(3)
) i_prf_sync (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .async_in(async_pins),
  .sync_out(synced_pins)
);
assign comparator_sync = synced_pins[0];
assign gate0_sync = synced_pins[1];
assign gate1_sync = synced_pins[2];

// comparator output change detect
assign comparator_change = comparator_sync ^ comparator_prev;

// register write decode
assign write_flags = wr_strobe && (addr == `PRF_OFS_FLAGS);
assign write_enable = wr_strobe && (addr == `PRF_OFS_ENABLE);
assign write_intctl = wr_strobe && (addr == `PRF_OFS_INTCTL);
assign write_rststat = wr_strobe && (addr == `PRF_OFS_RSTSTAT);
assign write_borctl = wr_strobe && (addr == `PRF_OFS_BORCTL);
assign write_apsel = wr_strobe && (addr == `PRF_OFS_APSEL);

// brown-out only acts while its reset is enabled
assign brownout_taken = brownout_reset && brownout_reset_enable;

// warm resets clear the request flags, enable, interrupt control and pin select, not the power-on flag or brown-out enable
assign warm_reset = brownout_taken || watchdog_reset ||
  external_reset_pin;

assign global_interrupt_enable = interrupt_control[`PRF_BIT_GIE];
assign peripheral_interrupt_enable = interrupt_control[`PRF_BIT_PERIPHERAL_INTERRUPT_ENABLE];
assign pending = peripheral_request_flags & enable_mask;

// event sets, independent of any enable
always @*
begin
  flag_set = 8'h00;
  flag_set[`PRF_BIT_ADC] = conversion_done;
  case (ccp_mode)
    `PRF_CCP_CAPTURE:
    begin
      flag_set[`PRF_BIT_CCP] = capture_event;
    end
    `PRF_CCP_COMPARE:
    begin
      flag_set[`PRF_BIT_CCP] = compare_match;
    end
    default:
    begin
      flag_set[`PRF_BIT_CCP] = 1'b0;
    end
  endcase
  flag_set[`PRF_BIT_CMP] = comparator_change && comparator_settle[2];
  flag_set[`PRF_BIT_TMR2] = period_match;
  flag_set[`PRF_BIT_TIMER_ONE_COUNT] = timer_one_overflow;
end

// software clears by writing ones; a new conversion clears bit 6
always @*
begin
  flag_clr = 8'h00;
  if (write_flags)
  begin
    flag_clr = wr_data;
  end
  if (conversion_start)
  begin
    flag_clr[`PRF_BIT_ADC] = 1'b1;
  end
end

// set wins over clear; unimplemented bits held at zero
always @*
begin
  next_flags = ((peripheral_request_flags & ~flag_clr) | flag_set) &
    `PRF_FLAG_MASK;
end

// reset status: software writes rearm, brown-out clears its own flag
always @*
begin
  next_power_on_flag = power_on_flag;
  next_brownout_status_flag = brownout_status_flag;
  if (write_rststat)
  begin
    next_power_on_flag = wr_data[`PRF_BIT_POR];
    next_brownout_status_flag = wr_data[`PRF_BIT_BOR];
  end
  if (brownout_taken)
  begin
    next_brownout_status_flag = 1'b0;
  end
end

// interrupt request, gated by both enables
always @*
begin
  next_irq = (|pending) && peripheral_interrupt_enable &&
    global_interrupt_enable;
end

// read mux, zero for unmapped addresses and idle cycles
always @*
begin
  next_rd_data = 8'h00;
  if (rd_strobe)
  begin
    case (addr)
      `PRF_OFS_FLAGS:
      begin
        next_rd_data = peripheral_request_flags & `PRF_FLAG_MASK;
      end
      `PRF_OFS_ENABLE:
      begin
        next_rd_data = enable_mask & `PRF_FLAG_MASK;
      end
      `PRF_OFS_INTCTL:
      begin
        next_rd_data = interrupt_control & `PRF_INTCTL_MASK;
      end
      `PRF_OFS_RSTSTAT:
      begin
        next_rd_data[`PRF_BIT_POR] = power_on_flag;
        next_rd_data[`PRF_BIT_BOR] = brownout_status_flag &&
          brownout_reset_enable;
      end
      `PRF_OFS_BORCTL:
      begin
        next_rd_data[`PRF_BIT_BOREN] = brownout_reset_enable;
      end
      `PRF_OFS_APSEL:
      begin
        next_rd_data = alternate_pin_select & `PRF_APSEL_MASK;
      end
      default:
      begin
        next_rd_data = 8'h00;
      end
    endcase
  end
end

// request flags and control registers
always @(posedge ref_clk or negedge resetn)
begin
  if (!resetn)
  begin
    peripheral_request_flags <= `PRF_FLAGS_RST;
    enable_mask <= `PRF_ENABLE_RST;
    interrupt_control <= `PRF_INTCTL_RST;
    alternate_pin_select <= `PRF_APSEL_RST;
    comparator_prev <= 1'b0;
    comparator_settle <= 3'h0;
  end
  else if (clk_en)
  begin
    comparator_prev <= comparator_sync;
    comparator_settle <= {comparator_settle[1:0], 1'b1};
    if (warm_reset)
    begin
      peripheral_request_flags <= `PRF_FLAGS_RST;
      enable_mask <= `PRF_ENABLE_RST;
      interrupt_control <= `PRF_INTCTL_RST;
      alternate_pin_select <= `PRF_APSEL_RST;
    end
    else
    begin
      peripheral_request_flags <= next_flags;
      if (write_enable)
      begin
        enable_mask <= wr_data & `PRF_FLAG_MASK;
      end
      if (write_intctl)
      begin
        interrupt_control <= wr_data & `PRF_INTCTL_MASK;
      end
      if (write_apsel)
      begin
        alternate_pin_select <= wr_data & `PRF_APSEL_MASK;
      end
    end
  end
end

// power-on flag and brown-out enable survive warm resets; a brown-out clears its own status flag
always @(posedge ref_clk or negedge resetn)
begin
  if (!resetn)
  begin
    power_on_flag <= `PRF_POR_RST;
    brownout_status_flag <= `PRF_BOR_RST;
    brownout_reset_enable <= `PRF_BOREN_RST;
  end
  else if (clk_en)
  begin
    power_on_flag <= next_power_on_flag;
    brownout_status_flag <= next_brownout_status_flag;
    if (write_borctl)
    begin
      brownout_reset_enable <= wr_data[`PRF_BIT_BOREN];
    end
  end
end

// read data and interrupt output
always @(posedge ref_clk or negedge resetn)
begin
  if (!resetn)
  begin
    rd_data <= 8'h00;
    irq <= 1'b0;
  end
  else if (clk_en)
  begin
    rd_data <= next_rd_data;
    irq <= next_irq;
  end
end

// pin routing of pwm channels and timer one gate
always @(posedge ref_clk or negedge resetn)
begin
  if (!resetn)
  begin
    pwm_a_pin0 <= 1'b0;
    pwm_a_pin0_oe <= 1'b0;
    pwm_a_pin1 <= 1'b0;
    pwm_a_pin1_oe <= 1'b0;
    pwm_b_pin0 <= 1'b0;
    pwm_b_pin0_oe <= 1'b0;
    pwm_b_pin1 <= 1'b0;
    pwm_b_pin1_oe <= 1'b0;
    timer_one_gate <= 1'b0;
  end
  else if (clk_en)
  begin
    pwm_a_pin0 <= pwm_output_a &&
      !alternate_pin_select[`PRF_BIT_APA];
    pwm_a_pin0_oe <= (ccp_mode == `PRF_CCP_PWM) &&
      !alternate_pin_select[`PRF_BIT_APA];
    pwm_a_pin1 <= pwm_output_a &&
      alternate_pin_select[`PRF_BIT_APA];
    pwm_a_pin1_oe <= (ccp_mode == `PRF_CCP_PWM) &&
      alternate_pin_select[`PRF_BIT_APA];
    pwm_b_pin0 <= pwm_output_b &&
      !alternate_pin_select[`PRF_BIT_APB];
    pwm_b_pin0_oe <= (ccp_mode == `PRF_CCP_PWM) &&
      !alternate_pin_select[`PRF_BIT_APB];
    pwm_b_pin1 <= pwm_output_b &&
      alternate_pin_select[`PRF_BIT_APB];
    pwm_b_pin1_oe <= (ccp_mode == `PRF_CCP_PWM) &&
      alternate_pin_select[`PRF_BIT_APB];
    if (alternate_pin_select[`PRF_BIT_APG])
    begin
      timer_one_gate <= gate1_sync;
    end
    else
    begin
      timer_one_gate <= gate0_sync;
    end
  end
end

endmodule

// *** prf_map.vh ***
// register map, field positions and reset values of the request flag bank
// assumes an 8-bit register port with a 4-bit word address
`ifndef PRF_MAP_VH
`define PRF_MAP_VH

`define PRF_ADDR_W 4
`define PRF_DATA_W 8

`define PRF_OFS_FLAGS 4'h0
`define PRF_OFS_ENABLE 4'h1
`define PRF_OFS_INTCTL 4'h2
`define PRF_OFS_RSTSTAT 4'h3
`define PRF_OFS_BORCTL 4'h4
`define PRF_OFS_APSEL 4'h5

`define PRF_BIT_ADC 6
`define PRF_BIT_CCP 5
`define PRF_BIT_CMP 3
`define PRF_BIT_TMR2 1
`define PRF_BIT_TIMER_ONE_COUNT 0
`define PRF_FLAG_MASK 8'h6b

`define PRF_BIT_GIE 7
`define PRF_BIT_PERIPHERAL_INTERRUPT_ENABLE 6
`define PRF_INTCTL_MASK 8'hc0

`define PRF_BIT_POR 1
`define PRF_BIT_BOR 0
`define PRF_BIT_BOREN 0

`define PRF_BIT_APA 0
`define PRF_BIT_APB 1
`define PRF_BIT_APG 4
`define PRF_APSEL_MASK 8'h13

`define PRF_FLAGS_RST 8'h00
`define PRF_ENABLE_RST 8'h00
`define PRF_INTCTL_RST 8'h00
`define PRF_APSEL_RST 8'h00
`define PRF_POR_RST 1'b0
`define PRF_BOR_RST 1'b0
`define PRF_BOREN_RST 1'b1

`define PRF_CCP_OFF 2'h0
`define PRF_CCP_CAPTURE 2'h1
`define PRF_CCP_COMPARE 2'h2
`define PRF_CCP_PWM 2'h3

`define PRF_SYNC_STAGES 2

`endif

// *** prf_sync.v ***
// two-stage synchroniser for inputs from outside the clock domain
// assumes the reader samples only the second stage
`timescale 1ns/1ps
module prf_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage_one;

always @(posedge ref_clk or negedge resetn)
begin
  if (!resetn)
  begin
    stage_one <= {WIDTH{1'b0}};
    sync_out <= {WIDTH{1'b0}};
  end
  else if (clk_en)
  begin
    stage_one <= async_in;
    sync_out <= stage_one;
  end
end

endmodule

// *** prf_flags_unused_guard.v ***
// holds no logic; the block lives in prf_flags.v and prf_sync.v
`timescale 1ns/1ps

// *** prf_flags_monitor.sv ***
// assertion checker for the request flag bank
// assumes it is bound to prf_flags and sees only its ports
`timescale 1ns/1ps
`include "prf_map.vh"
module prf_flags_chk (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  // register port
  input wire [`PRF_ADDR_W-1:0] addr,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [`PRF_DATA_W-1:0] rd_data,
  // events
  input wire [1:0] ccp_mode,
  input wire period_match,
  input wire timer_one_overflow,
  input wire brownout_reset,
  input wire watchdog_reset,
  input wire external_reset_pin,
  // outputs
  input wire brownout_reset_enable,
  input wire irq,
  input wire pwm_a_pin0_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire calm;
  assign calm = clk_en && !watchdog_reset && !external_reset_pin &&
    !brownout_reset;
  // register read taken at this edge
  sequence s_rd(a);
    clk_en && rd_strobe && addr == a;
  endsequence
  // event, quiet cycle, then a read of the given register
  sequence s_after(ev, a);
    calm && ev ##1 calm && !wr_strobe ##1 s_rd(a);
  endsequence
  a_flags_unimpl_zero: assert property (s_rd(`PRF_OFS_FLAGS) |=>
    (rd_data & 8'h94) == 8'h00) else $error("flag spare bits set");
  a_stat_unimpl_zero: assert property (s_rd(`PRF_OFS_RSTSTAT) |=>
    rd_data[7:2] == 6'h00) else $error("status spare bits set");
  a_bor_off_zero: assert property (s_rd(`PRF_OFS_RSTSTAT) &&
    !brownout_reset_enable |=> !rd_data[0]) else $error("bor bit not 0");
  a_period_sets: assert property (s_after(period_match,
    `PRF_OFS_FLAGS) |=> rd_data[1]) else $error("period flag not set");
  a_overflow_sets: assert property (s_after(timer_one_overflow,
    `PRF_OFS_FLAGS) |=> rd_data[0]) else $error("overflow flag not set");
  a_bor_clears_flag: assert property (brownout_reset_enable && clk_en &&
    brownout_reset ##1 clk_en && !wr_strobe ##1 s_rd(`PRF_OFS_RSTSTAT)
    |=> !rd_data[0]) else $error("bor flag not cleared");
  a_warm_irq_low: assert property (clk_en && watchdog_reset ##1 clk_en
    |=> !irq) else $error("irq after warm reset");
  a_oe_needs_pwm: assert property (pwm_a_pin0_oe && $past(clk_en) |->
    $past(ccp_mode) == `PRF_CCP_PWM) else $error("oe outside pwm mode");
endmodule
bind prf_flags prf_flags_chk i_prf_flags_chk (.ref_clk(ref_clk),
  .resetn(resetn), .clk_en(clk_en), .addr(addr), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data(rd_data), .ccp_mode(ccp_mode),
  .period_match(period_match), .timer_one_overflow(timer_one_overflow),
  .brownout_reset(brownout_reset), .watchdog_reset(watchdog_reset),
  .external_reset_pin(external_reset_pin), .irq(irq),
  .brownout_reset_enable(brownout_reset_enable),
  .pwm_a_pin0_oe(pwm_a_pin0_oe));

// *** test_prf_flags.sv ***
// self-checking bench for the request flag bank
// assumes prf_flags and its checker are compiled before it
`timescale 1ns/1ps
`include "prf_map.vh"
module test_prf_flags;
  logic ref_clk = 0;
  logic resetn = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_strobe = 0;
  logic rd_strobe = 0;
  logic [1:0] ccp_mode = 2'h0;
  logic cmp = 0;
  logic [8:0] ev = 9'h000;
  wire [7:0] rd_data;
  wire irq;
  wire bor_en;
  wire [1:0] oe;
  logic clk_en = 1;
  logic pwm_a = 1;
  logic pwm_b = 0;
  logic [1:0] gpin = 2'h0;
  wire [3:0] pin;
  wire [1:0] oe_b;
  wire gate;
  integer n_fail = 0;
  integer num_checks = 0;
  integer cycles = 0;
  prf_flags i_prf_flags (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .conversion_start(ev[0]), .conversion_done(ev[1]),
    .ccp_mode(ccp_mode), .capture_event(ev[2]), .compare_match(ev[3]),
    .comparator_out(cmp), .period_match(ev[4]),
    .timer_one_overflow(ev[5]), .brownout_reset(ev[6]),
    .watchdog_reset(ev[7]), .external_reset_pin(ev[8]),
    .brownout_reset_enable(bor_en), .irq(irq), .pwm_output_a(pwm_a),
    .pwm_output_b(pwm_b), .pwm_a_pin0(pin[0]), .pwm_a_pin0_oe(oe[0]),
    .pwm_a_pin1(pin[1]), .pwm_a_pin1_oe(oe[1]), .pwm_b_pin0(pin[2]),
    .pwm_b_pin0_oe(oe_b[0]), .pwm_b_pin1(pin[3]),
    .pwm_b_pin1_oe(oe_b[1]), .gate_pin0(gpin[0]), .gate_pin1(gpin[1]),
    .timer_one_gate(gate));
  task complete_run;
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1;
    @(posedge ref_clk);
    wr_strobe <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_strobe <= 1;
    @(posedge ref_clk);
    rd_strobe <= 0;
    #1 chk("rd_data", e, rd_data);
  endtask
  task pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1;
    @(posedge ref_clk);
    ev <= 9'h000;
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  task t_reset;
    rd(`PRF_OFS_FLAGS, 8'h00);
    rd(`PRF_OFS_RSTSTAT, 8'h00);
    rd(`PRF_OFS_BORCTL, 8'h01);
    rd(4'hf, 8'h00);
    chk("bor_en", 8'h01, {7'h00, bor_en});
  endtask
  task t_events;
    ccp_mode <= `PRF_CCP_CAPTURE;
    pulse(2);
    rd(`PRF_OFS_FLAGS, 8'h20);
    wr(`PRF_OFS_FLAGS, 8'h20);
    ccp_mode <= `PRF_CCP_COMPARE;
    pulse(2);
    rd(`PRF_OFS_FLAGS, 8'h00);
    pulse(3);
    rd(`PRF_OFS_FLAGS, 8'h20);
    wr(`PRF_OFS_FLAGS, 8'h20);
    ccp_mode <= `PRF_CCP_PWM;
    pulse(3);
    rd(`PRF_OFS_FLAGS, 8'h00);
    chk("oe", 8'h01, {6'h00, oe});
    wr(`PRF_OFS_APSEL, 8'h01);
    rd(`PRF_OFS_APSEL, 8'h01);
    chk("oe", 8'h02, {6'h00, oe});
    ccp_mode <= `PRF_CCP_OFF;
    pulse(1);
    pulse(4);
    cmp <= 1;
    repeat (5) @(posedge ref_clk);
    pulse(5);
    rd(`PRF_OFS_FLAGS, 8'h4b);
    pulse(0);
    rd(`PRF_OFS_FLAGS, 8'h0b);
    wr(`PRF_OFS_FLAGS, 8'h09);
    rd(`PRF_OFS_FLAGS, 8'h02);
  endtask
  task t_irq;
    wr(`PRF_OFS_ENABLE, 8'h02);
    wr(`PRF_OFS_INTCTL, 8'hc0);
    irq_is(1);
    wr(`PRF_OFS_INTCTL, 8'h80);
    irq_is(0);
    wr(`PRF_OFS_INTCTL, 8'hc0);
    wr(`PRF_OFS_FLAGS, 8'h02);
    irq_is(0);
    pulse(4);
    rd(`PRF_OFS_FLAGS, 8'h02);
    irq_is(1);
    pulse(7);
    irq_is(0);
    rd(`PRF_OFS_ENABLE, 8'h00);
  endtask
  task t_pins;
    ccp_mode <= `PRF_CCP_PWM;
    pwm_b <= 1;
    gpin <= 2'h2;
    repeat (4) @(posedge ref_clk);
    #1 chk("pins", 8'h55, {pin, oe_b, oe});
    chk("gate", 8'h00, {7'h00, gate});
    wr(`PRF_OFS_APSEL, 8'h13);
    pwm_a <= 0;
    repeat (4) @(posedge ref_clk);
    #1 chk("pins", 8'h8a, {pin, oe_b, oe});
    chk("gate", 8'h01, {7'h00, gate});
    clk_en <= 0;
    gpin <= 2'h0;
    pulse(5);
    repeat (4) @(posedge ref_clk);
    #1 chk("gate", 8'h01, {7'h00, gate});
    clk_en <= 1;
    rd(`PRF_OFS_FLAGS, 8'h00);
    ccp_mode <= `PRF_CCP_OFF;
  endtask
  task t_status;
    wr(`PRF_OFS_RSTSTAT, 8'h03);
    rd(`PRF_OFS_RSTSTAT, 8'h03);
    pulse(7);
    rd(`PRF_OFS_RSTSTAT, 8'h03);
    pulse(8);
    rd(`PRF_OFS_RSTSTAT, 8'h03);
    pulse(6);
    rd(`PRF_OFS_RSTSTAT, 8'h02);
    wr(`PRF_OFS_RSTSTAT, 8'h03);
    wr(`PRF_OFS_BORCTL, 8'h00);
    rd(`PRF_OFS_RSTSTAT, 8'h02);
    chk("bor_en", 8'h00, {7'h00, bor_en});
    pulse(6);
    wr(`PRF_OFS_BORCTL, 8'h01);
    rd(`PRF_OFS_RSTSTAT, 8'h03);
    resetn <= 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    rd(`PRF_OFS_RSTSTAT, 8'h00);
    rd(`PRF_OFS_FLAGS, 8'h00);
  endtask
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      complete_run;
    end
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    t_reset;
    t_events;
    t_irq;
    t_pins;
    t_status;
    complete_run;
  end
endmodule
